// file: design/haptic_seq_regs.svh
`ifndef HAPTIC_SEQ_REGS_SVH
`define HAPTIC_SEQ_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_GO 8'h0c
`define IDX_SLOT_FIRST 8'h0f
`define IDX_SLOT_LAST 8'h16
`define IDX_REPEAT_1_TO_4 8'h17
`define IDX_REPEAT_5_TO_8 8'h18
`define IDX_STATUS 8'h1a

// Field positions
`define GO_BIT 0
`define SLOT_PAUSE_BIT 7
`define SLOT_CODE_MSB 6
`define REPEAT_FIELD_W 2

// Reset values
`define SLOT_RESET 8'h00
`define REPEAT_RESET 8'h00

// Sequencer constants
`define STOP_CODE 7'h00
`define FIRST_SLOT 3'h0
`define LAST_SLOT 3'h7
`define SLOT_COUNT 8

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_IDX_MSB 9
`define ADDR_IDX_LSB 2

// Timing
`define MCLK_PERIOD_NS 100
`define PAUSE_UNIT_NS 10000000
`define PAUSE_UNIT_CYCLES (`PAUSE_UNIT_NS / `MCLK_PERIOD_NS)

`endif

// file: design/haptic_seq_pkg.sv
package haptic_seq_pkg;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_type;

    typedef struct packed {
        logic pause;
        logic [6:0] code;
    } slot_type;

    typedef enum logic [1:0] {
        S_IDLE,
        S_FETCH,
        S_EFFECT,
        S_PAUSE
    } seq_state_type;

endpackage

// file: design/pause_timer.sv
`include "haptic_seq_regs.svh"

module pause_timer
    import haptic_seq_pkg::*;
#(
    parameter int UNIT_CYCLES = `PAUSE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire logic [6:0] units,
    // Result
    output logic done
);

    logic [23:0] pre_reg, pre_next;
    logic [6:0] left_reg, left_next;
    logic run_reg, run_next;
    logic done_reg, done_next;
    logic tick;

    // Unit enable pulse from the divider
    assign tick = run_reg && (pre_reg == 24'(UNIT_CYCLES - 1));

    always_comb begin
        pre_next = pre_reg;
        left_next = left_reg;
        run_next = run_reg;
        done_next = 1'b0;
        if (start) begin
            pre_next = 24'h0;
            left_next = units;
            run_next = (units != `STOP_CODE);
            done_next = (units == `STOP_CODE);
        end else if (run_reg) begin
            pre_next = tick ? 24'h0 : pre_reg + 24'h1;
            if (tick) begin
                left_next = left_reg - 7'h1;
                if (left_reg == 7'h1) begin
                    run_next = 1'b0;
                    done_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= 24'h0;
            left_reg <= 7'h0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            left_reg <= left_next;
            run_reg <= run_next;
            done_reg <= done_next;
        end
    end

    assign done = done_reg;

    // A one-unit idle does not end in its start cycle or the next
    property p_unit_len;
        @(posedge mclk) disable iff (!rst_b)
        (start && units == 7'h1) |-> !done_reg [*2];
    endproperty
    a_unit_len: assert property (p_unit_len)
        else $error("pause ended too early");

endmodule // pause_timer

// file: design/haptic_seq.sv
// Functional notes
// - A slot with its pause bit set idles for 10 ms times its 7-bit value.
// - A slot with its pause bit clear plays its 7-bit value as an effect.
// - The effect identifier is passed on as the library index to play.
// - Setting the go bit starts playback at the first slot.
// - When a slot finishes, the next slot is fetched and played if non-zero.
// - The sequence ends at the first zero slot or after all eight slots.
// - An identifier of zero is a stop marker and plays nothing.
// - The eighth slot holds pause at bit 7 and value at 6:0, RW, reset 0.
// - Each slot is played its configured number of times before advancing.
// - A repeat field of n plays the slot n plus one times.
// - Repeats for slots 1 to 4 sit at bits 1-0 up to 7-6, RW, reset 0.
`include "haptic_seq_regs.svh"

module haptic_seq
    import haptic_seq_pkg::*;
#(
    parameter int PAUSE_CYCLES = `PAUSE_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    input wire axil_req_type bus_req,
    output axil_rsp_type bus_rsp,
    // Effect playback engine
    output logic effect_start,
    output logic [6:0] effect_index,
    input wire logic effect_done,
    // Status
    output logic seq_busy
);

    // Register store
    slot_type slot_reg [`SLOT_COUNT];
    slot_type slot_next [`SLOT_COUNT];
    logic [7:0] rep_lo_reg, rep_lo_next;
    logic [7:0] rep_hi_reg, rep_hi_next;

    // Bus state
    axil_rsp_type rsp_reg, rsp_next;
    logic aw_full_reg, aw_full_next;
    logic w_full_reg, w_full_next;
    logic [7:0] aw_idx_reg, aw_idx_next;
    logic aw_bad_reg, aw_bad_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic wr_en, go_accept;

    // Sequencer state
    seq_state_type state_reg, state_next;
    logic [2:0] idx_reg, idx_next;
    logic [1:0] left_reg, left_next;
    logic start_reg, start_next;
    logic [6:0] index_reg, index_next;
    logic busy_reg, busy_next;
    logic pause_go, pause_done, slot_done;
    slot_type cur;

    function automatic logic [1:0] repeat_of(input logic [2:0] i,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [15:0] all;
        all = {hi, lo};
        return all[{i, 1'b0} +: `REPEAT_FIELD_W];
    endfunction

    function automatic logic idx_ok(input logic [11:0] a);
        logic [7:0] i;
        i = a[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
        return (a[11:10] == 2'h0) &&
               (i == `IDX_GO || i == `IDX_STATUS ||
                (i >= `IDX_SLOT_FIRST && i <= `IDX_REPEAT_5_TO_8));
    endfunction

    // Write port: address and data taken in either order
    assign wr_en = aw_full_reg && w_full_reg && !rsp_reg.bvalid;
    assign go_accept = wr_en && !aw_bad_reg && w_lane_reg &&
                       aw_idx_reg == `IDX_GO && w_data_reg[`GO_BIT] &&
                       state_reg == S_IDLE;

    always_comb begin
        rsp_next = rsp_reg;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_idx_next = aw_idx_reg;
        aw_bad_next = aw_bad_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        slot_next = slot_reg;
        rep_lo_next = rep_lo_reg;
        rep_hi_next = rep_hi_reg;
        if (bus_req.awvalid && rsp_reg.awready) begin
            aw_full_next = 1'b1;
            aw_idx_next = bus_req.awaddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
            aw_bad_next = !idx_ok(bus_req.awaddr);
        end
        if (bus_req.wvalid && rsp_reg.wready) begin
            w_full_next = 1'b1;
            w_data_next = bus_req.wdata[7:0];
            w_lane_next = bus_req.wstrb[0];
        end
        if (wr_en) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            rsp_next.bvalid = 1'b1;
            rsp_next.bresp = aw_bad_reg ? `RESP_SLVERR : `RESP_OKAY;
            if (!aw_bad_reg && w_lane_reg) begin
                if (aw_idx_reg >= `IDX_SLOT_FIRST &&
                    aw_idx_reg <= `IDX_SLOT_LAST) begin
                    slot_next[3'(aw_idx_reg - `IDX_SLOT_FIRST)] =
                        slot_type'(w_data_reg);
                end
                if (aw_idx_reg == `IDX_REPEAT_1_TO_4) begin
                    rep_lo_next = w_data_reg;
                end
                if (aw_idx_reg == `IDX_REPEAT_5_TO_8) begin
                    rep_hi_next = w_data_reg;
                end
            end
        end else if (rsp_reg.bvalid && bus_req.bready) begin
            rsp_next.bvalid = 1'b0;
        end
        rsp_next.awready = !aw_full_next;
        rsp_next.wready = !w_full_next;
        // Read port: one read at a time, answered the edge after address
        if (rsp_reg.rvalid && bus_req.rready) begin
            rsp_next.rvalid = 1'b0;
        end
        if (bus_req.arvalid && rsp_reg.arready) begin
            rsp_next.rvalid = 1'b1;
            rsp_next.rresp = `RESP_OKAY;
            rsp_next.rdata = 32'h0;
            if (!idx_ok(bus_req.araddr)) begin
                rsp_next.rresp = `RESP_SLVERR;
            end else begin
                case (bus_req.araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB])
                    `IDX_GO: rsp_next.rdata[`GO_BIT] = busy_reg;
                    `IDX_REPEAT_1_TO_4: rsp_next.rdata[7:0] = rep_lo_reg;
                    `IDX_REPEAT_5_TO_8: rsp_next.rdata[7:0] = rep_hi_reg;
                    `IDX_STATUS: rsp_next.rdata[7:0] =
                        {busy_reg, idx_reg, 2'(state_reg), left_reg};
                    default: rsp_next.rdata[7:0] = slot_reg[3'(
                        bus_req.araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB] -
                        `IDX_SLOT_FIRST)];
                endcase
            end
        end
        rsp_next.arready = !rsp_next.rvalid;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_reg <= '0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_idx_reg <= 8'h0;
            aw_bad_reg <= 1'b0;
            w_data_reg <= 8'h0;
            w_lane_reg <= 1'b0;
            for (int i = 0; i < `SLOT_COUNT; i++) begin
                slot_reg[i] <= `SLOT_RESET;
            end
            rep_lo_reg <= `REPEAT_RESET;
            rep_hi_reg <= `REPEAT_RESET;
        end else begin
            rsp_reg <= rsp_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_idx_reg <= aw_idx_next;
            aw_bad_reg <= aw_bad_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            slot_reg <= slot_next;
            rep_lo_reg <= rep_lo_next;
            rep_hi_reg <= rep_hi_next;
        end
    end

    // Slots are read live, so edits ahead of the walk take effect
    assign cur = slot_reg[idx_reg];
    assign pause_go = state_reg == S_FETCH && cur.code != `STOP_CODE &&
                      cur.pause;
    assign slot_done = (state_reg == S_EFFECT && effect_done) ||
                       (state_reg == S_PAUSE && pause_done);

    pause_timer #(
        .UNIT_CYCLES(PAUSE_CYCLES)
    ) u_pause (
        .mclk(mclk),
        .rst_b(rst_b),
        .start(pause_go),
        .units(cur.code),
        .done(pause_done)
    );

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        left_next = left_reg;
        start_next = 1'b0;
        index_next = index_reg;
        case (state_reg)
            S_IDLE: begin
                if (go_accept) begin
                    state_next = S_FETCH;
                    idx_next = `FIRST_SLOT;
                    left_next = repeat_of(`FIRST_SLOT, rep_lo_reg,
                                          rep_hi_reg);
                end
            end
            S_FETCH: begin
                if (cur.code == `STOP_CODE) begin
                    state_next = S_IDLE;
                end else if (cur.pause) begin
                    state_next = S_PAUSE;
                end else begin
                    state_next = S_EFFECT;
                    start_next = 1'b1;
                    index_next = cur.code;
                end
            end
            S_EFFECT, S_PAUSE: begin
                if (slot_done) begin
                    state_next = S_FETCH;
                    if (left_reg != 2'h0) begin
                        left_next = left_reg - 2'h1;
                    end else if (idx_reg == `LAST_SLOT) begin
                        state_next = S_IDLE;
                    end else begin
                        idx_next = idx_reg + 3'h1;
                        left_next = repeat_of(idx_reg + 3'h1, rep_lo_reg,
                                              rep_hi_reg);
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
        busy_next = state_next != S_IDLE;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_IDLE;
            idx_reg <= `FIRST_SLOT;
            left_reg <= 2'h0;
            start_reg <= 1'b0;
            index_reg <= 7'h0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            left_reg <= left_next;
            start_reg <= start_next;
            index_reg <= index_next;
            busy_reg <= busy_next;
        end
    end

    assign bus_rsp = rsp_reg;
    assign effect_start = start_reg;
    assign effect_index = index_reg;
    assign seq_busy = busy_reg;

    property p_go_first;
        @(posedge mclk) disable iff (!rst_b)
        go_accept |=> state_reg == S_FETCH && idx_reg == `FIRST_SLOT;
    endproperty
    a_go_first: assert property (p_go_first)
        else $error("go did not start at first slot");

    property p_pause_silent;
        @(posedge mclk) disable iff (!rst_b)
        pause_go |=> state_reg == S_PAUSE && !start_reg;
    endproperty
    a_pause_silent: assert property (p_pause_silent)
        else $error("pause slot started an effect");

    property p_play_index;
        @(posedge mclk) disable iff (!rst_b)
        (state_reg == S_FETCH && !cur.pause && cur.code != `STOP_CODE)
            |=> start_reg && index_reg == $past(cur.code);
    endproperty
    a_play_index: assert property (p_play_index)
        else $error("effect index does not match slot");

    property p_stop_marker;
        @(posedge mclk) disable iff (!rst_b)
        (state_reg == S_FETCH && cur.code == `STOP_CODE)
            |=> state_reg == S_IDLE && !start_reg ##1 !start_reg;
    endproperty
    a_stop_marker: assert property (p_stop_marker)
        else $error("stop marker did not halt");

    property p_advance;
        @(posedge mclk) disable iff (!rst_b)
        (slot_done && left_reg == 2'h0 && idx_reg != `LAST_SLOT)
            |=> idx_reg == $past(idx_reg) + 3'h1 && state_reg == S_FETCH;
    endproperty
    a_advance: assert property (p_advance)
        else $error("slot did not advance");

    property p_last_ends;
        @(posedge mclk) disable iff (!rst_b)
        (slot_done && left_reg == 2'h0 && idx_reg == `LAST_SLOT)
            |=> state_reg == S_IDLE ##1 !busy_reg;
    endproperty
    a_last_ends: assert property (p_last_ends)
        else $error("sequence ran past last slot");

    property p_repeat;
        @(posedge mclk) disable iff (!rst_b)
        (slot_done && left_reg != 2'h0)
            |=> $stable(idx_reg) && left_reg == $past(left_reg) - 2'h1;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat count not honoured");

    property p_reload;
        @(posedge mclk) disable iff (!rst_b)
        $changed(idx_reg) && busy_reg |->
            left_reg == repeat_of(idx_reg, rep_lo_reg, rep_hi_reg);
    endproperty
    a_reload: assert property (p_reload)
        else $error("repeat counter not reloaded");

    property p_slot8_write;
        @(posedge mclk) disable iff (!rst_b)
        (wr_en && !aw_bad_reg && w_lane_reg && aw_idx_reg == `IDX_SLOT_LAST)
            |=> slot_reg[`LAST_SLOT] == $past(w_data_reg);
    endproperty
    a_slot8_write: assert property (p_slot8_write)
        else $error("eighth slot write lost");

endmodule // haptic_seq

// file: testbench/effect_engine_model.sv
module effect_engine_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Playback request
    input wire logic effect_start,
    input wire logic [6:0] effect_index,
    // Completion
    output logic effect_done = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [6:0] played [$];
    logic running = 1'b0;
    int wait_left = 0;

    // Delay follows play count, so prompt and slow answers both occur
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            effect_done <= 1'b0;
            running <= 1'b0;
        end else begin
            effect_done <= 1'b0;
            if (effect_start) begin
                played.push_back(effect_index);
                running <= 1'b1;
                wait_left <= (played.size() % 3) * 4;
            end else if (running && wait_left == 0) begin
                effect_done <= 1'b1;
                running <= 1'b0;
            end else if (running) begin
                wait_left <= wait_left - 1;
            end
        end
    end
endmodule // effect_engine_model

// file: testbench/haptic_seq_bench.sv
module haptic_seq_bench
    import haptic_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int P = 5;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    axil_req_type req = '0;
    axil_rsp_type rsp;
    logic effect_start;
    logic [6:0] effect_index;
    logic effect_done;
    logic seq_busy;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 32'h5716470b;
    int dur;
    logic [7:0] slot [8];
    logic [15:0] reps;
    logic [6:0] exp_q [$];
    logic [31:0] rd;
    logic [31:0] v;
    logic [1:0] rr;

    always #50 mclk = ~mclk;

    haptic_seq #(.PAUSE_CYCLES(P)) i_dut (
        .mclk(mclk),
        .rst_b(rst_b),
        .bus_req(req),
        .bus_rsp(rsp),
        .effect_start(effect_start),
        .effect_index(effect_index),
        .effect_done(effect_done),
        .seq_busy(seq_busy)
    );

    effect_engine_model i_engine (
        .mclk(mclk),
        .rst_b(rst_b),
        .effect_start(effect_start),
        .effect_index(effect_index),
        .effect_done(effect_done)
    );

    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
        @(posedge mclk);
        req.awvalid <= 1'b1;
        req.awaddr <= {2'h0, idx, 2'h0};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] idx);
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr <= {2'h0, idx, 2'h0};
        req.rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    // Reference walk of the slots, then one playback compared play by play
    task automatic run_seq(input bit extra_go);
        exp_q.delete();
        i_engine.played.delete();
        for (int s = 0; s < 8; s++) write_reg(8'h0f + 8'(s), slot[s]);
        write_reg(8'h17, reps[7:0]);
        write_reg(8'h18, reps[15:8]);
        for (int s = 0; s < 8; s++) begin
            if (slot[s][6:0] == 7'h00) break;
            for (int r = 0; r <= int'(reps[2*s +: 2]); r++) begin
                if (!slot[s][7]) exp_q.push_back(slot[s][6:0]);
            end
        end
        write_reg(8'h0c, 8'h01);
        // Second start lands while busy and must change nothing
        if (extra_go) begin
            write_reg(8'h0c, 8'h01);
            read_reg(8'h0c);
            check("go busy", 32'h1, rd);
        end
        dur = 0;
        @(posedge mclk);
        while (seq_busy !== 1'b0) begin
            @(posedge mclk);
            dur++;
        end
        read_reg(8'h0c);
        check("go idle", 32'h0, rd);
        check("play count", exp_q.size(), i_engine.played.size());
        foreach (exp_q[i]) begin
            check("effect index", {25'h0, exp_q[i]},
                  {25'h0, i_engine.played[i]});
        end
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        read_reg(8'h16);
        check("slot8 reset", 32'h0, rd);
        read_reg(8'h17);
        check("repeat reset", 32'h0, rd);
        read_reg(8'h30);
        check("unmapped resp", 32'h2, {30'h0, rr});
        write_reg(8'h30, 8'h55);
        check("unmapped bresp", 32'h2, {30'h0, rr});
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            write_reg(8'h16, v[7:0]);
            check("write resp", 32'h0, {30'h0, rr});
            read_reg(8'h16);
            check("slot8 readback", {24'h0, v[7:0]}, rd);
            write_reg(8'h17, v[15:8]);
            read_reg(8'h17);
            check("repeat readback", {24'h0, v[15:8]}, rd);
        end
        // All eight slots, every repeat code, each slot reloads its count
        for (int s = 0; s < 8; s++) slot[s] = 8'(s * 9 + 1);
        reps = 16'he4e4;
        run_seq(1'b1);
        // Code zero stops even with the pause bit set
        slot[2] = 8'h80;
        run_seq(1'b0);
        slot[0] = 8'h83;
        slot[1] = 8'h00;
        reps = 16'h0001;
        run_seq(1'b0);
        check("pause span", 32'h1,
              {31'h0, (dur >= 6 * P && dur <= 6 * P + 12)});
        for (int k = 0; k < 6; k++) begin
            for (int s = 0; s < 8; s++) begin
                v = $random(seed);
                slot[s] = (v[9:8] == 2'h0) ? {6'h20, v[1:0]}
                                           : {1'b0, v[6:0]};
            end
            v = $random(seed);
            reps = v[15:0];
            run_seq(1'b0);
        end
        read_reg(8'h1a);
        check("status busy", 32'h0, {31'h0, rd[7]});
        end_sim();
    end
endmodule // haptic_seq_bench
